// *** core/code_map.sv ***
// code mapping: turns the stored value into the unsigned code for the analog core
`timescale 1ns/1ps
`default_nettype none
module code_map (
  // stored value and format
  input wire logic [7:0] value,
  input wire logic signed_fmt,
  // mapped code
  output logic [7:0] code
);
  // flip the top bit for two's complement data
  assign code = signed_fmt ? (value ^ dac_fmt_pkg::SIGN_FLIP) : value;
endmodule : code_map
`default_nettype wire

// *** core/dac_fmt_pkg.sv ***
// package: register map, field positions and reset values of the converter control block
package dac_fmt_pkg;
  localparam logic [1:0] CTRL_OFS = 2'h0;
  localparam logic [1:0] RSVD_OFS = 2'h1;
  localparam logic [1:0] LEFT_OFS = 2'h2;
  localparam logic [1:0] RIGHT_OFS = 2'h3;
  localparam int ENABLE_BIT = 7;
  localparam int JUSTIFY_BIT = 3;
  localparam int SIGNED_BIT = 2;
  localparam int WAIT_BIT = 1;
  localparam int OE_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h8F;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] SIGN_FLIP = 8'h80;

  // control register fields
  typedef struct packed {
    logic converter_enable;
    logic justify_right_sel;
    logic signed_format_sel;
    logic stop_in_wait;
    logic output_drive_enable;
  } ctrl_t;

  // whole block state
  typedef struct packed {
    ctrl_t ctrl;
    logic [7:0] value;
    logic [7:0] rdata;
    logic [7:0] code;
    logic active;
  } dac_state_t;
endpackage : dac_fmt_pkg

// *** core/dac_format_ctrl.sv ***
// converter control block: registers, data formatting and analog core control
`timescale 1ns/1ps
`default_nettype none
module dac_format_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // system mode
  input wire logic wait_mode,
  // analog core
  output logic [7:0] core_code,
  output logic core_power_up,
  output logic converting,
  output logic analog_out_pin_oe
);
  dac_fmt_pkg::dac_state_t st_r;
  dac_fmt_pkg::dac_state_t st_nxt;
  logic [7:0] mapped;
  logic wait_stop;
  logic run;

  // register index decode, shared by the checks below
  function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
    return a == ofs;
  endfunction : hit

  // format mapping of the stored value
  code_map u_map (
    .value(st_r.value),
    .signed_fmt(st_r.ctrl.signed_format_sel),
    .code(mapped)
  );

  // core runs only when enabled and not parked by wait mode
  assign wait_stop = st_r.ctrl.stop_in_wait & wait_mode;
  assign run = st_r.ctrl.converter_enable & ~wait_stop;

  // next state: register writes, read data and core code
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    if (wr) begin
      if (addr == dac_fmt_pkg::CTRL_OFS) begin
        st_nxt.ctrl.converter_enable = wdata[dac_fmt_pkg::ENABLE_BIT];
        st_nxt.ctrl.justify_right_sel = wdata[dac_fmt_pkg::JUSTIFY_BIT];
        st_nxt.ctrl.signed_format_sel = wdata[dac_fmt_pkg::SIGNED_BIT];
        st_nxt.ctrl.stop_in_wait = wdata[dac_fmt_pkg::WAIT_BIT];
        st_nxt.ctrl.output_drive_enable = wdata[dac_fmt_pkg::OE_BIT];
      end else if (addr == dac_fmt_pkg::LEFT_OFS) begin
        if (!st_r.ctrl.justify_right_sel) begin
          st_nxt.value = wdata;
        end
      end else if (addr == dac_fmt_pkg::RIGHT_OFS) begin
        if (st_r.ctrl.justify_right_sel) begin
          st_nxt.value = wdata;
        end
      end
    end
    if (rd) begin
      if (addr == dac_fmt_pkg::CTRL_OFS) begin
        st_nxt.rdata = {st_r.ctrl.converter_enable, 3'h0, st_r.ctrl.justify_right_sel,
                        st_r.ctrl.signed_format_sel, st_r.ctrl.stop_in_wait,
                        st_r.ctrl.output_drive_enable};
      end else if (addr == dac_fmt_pkg::LEFT_OFS) begin
        st_nxt.rdata = st_r.ctrl.justify_right_sel ? 8'h00 : st_r.value;
      end else if (addr == dac_fmt_pkg::RIGHT_OFS) begin
        st_nxt.rdata = st_r.ctrl.justify_right_sel ? st_r.value : 8'h00;
      end
    end
    st_nxt.active = run;
    st_nxt.code = mapped;
  end

  // state register, synchronous reset powers down and aborts
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r.ctrl <= '0;
      st_r.value <= dac_fmt_pkg::DATA_RESET;
      st_r.rdata <= 8'h00;
      st_r.code <= 8'h00;
      st_r.active <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign rdata = st_r.rdata;
  assign core_code = st_r.code;
  assign core_power_up = st_r.active;
  assign converting = st_r.active;
  // pin drive needs the registered run flag and both enables as they stand now
  assign analog_out_pin_oe = st_r.active & st_r.ctrl.converter_enable & st_r.ctrl.output_drive_enable;

  // checks

  // right location reads zero while left justified
  right_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    (rd && hit(addr, dac_fmt_pkg::RIGHT_OFS) && !st_r.ctrl.justify_right_sel) |=> rdata == 8'h00)
    else $error("right location not zero");

  // right location writes dropped while left justified
  right_ign_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr && hit(addr, dac_fmt_pkg::RIGHT_OFS) && !st_r.ctrl.justify_right_sel) |=> $stable(st_r.value))
    else $error("ignored write changed value");

  // right location stores a write while right justified
  right_rw_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr && hit(addr, dac_fmt_pkg::RIGHT_OFS) && st_r.ctrl.justify_right_sel) |=> st_r.value == $past(wdata))
    else $error("right write lost");

  // right location reads back the stored value while right justified
  right_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (rd && hit(addr, dac_fmt_pkg::RIGHT_OFS) && st_r.ctrl.justify_right_sel) |=> rdata == $past(st_r.value))
    else $error("right read wrong");

  // left location reads zero while right justified
  left_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    (rd && hit(addr, dac_fmt_pkg::LEFT_OFS) && st_r.ctrl.justify_right_sel) |=> rdata == 8'h00)
    else $error("left location not zero");

  // left location writes dropped while right justified
  left_ign_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr && hit(addr, dac_fmt_pkg::LEFT_OFS) && st_r.ctrl.justify_right_sel) |=> $stable(st_r.value))
    else $error("left write not ignored");

  // left location stores a write while left justified
  left_rw_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr && hit(addr, dac_fmt_pkg::LEFT_OFS) && !st_r.ctrl.justify_right_sel) |=> st_r.value == $past(wdata))
    else $error("left write lost");

  // unsigned data passes straight through as a linear code
  code_lin_a: assert property (@(posedge core_clk) disable iff (reset)
    (!st_r.ctrl.signed_format_sel && $stable(st_r.value) && $stable(st_r.ctrl)) |=> core_code == $past(st_r.value))
    else $error("unsigned code wrong");

  // signed data lands on the unsigned scale with the top bit flipped
  sign_map_a: assert property (@(posedge core_clk) disable iff (reset)
    (st_r.ctrl.signed_format_sel && $stable(st_r.value) && $stable(st_r.ctrl))
    |=> core_code == {~$past(st_r.value[7]), $past(st_r.value[6:0])})
    else $error("signed code wrong");

  // unsigned data write reaches the core two edges later
  code_reg_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr && hit(addr, dac_fmt_pkg::RIGHT_OFS) && st_r.ctrl.justify_right_sel && !st_r.ctrl.signed_format_sel)
    |=> ##1 core_code == $past(wdata, 2))
    else $error("core code not updated");

  // enable starts conversion while wait mode is off
  start_a: assert property (@(posedge core_clk) disable iff (reset)
    (st_r.ctrl.converter_enable && !wait_mode) |=> converting)
    else $error("conversion did not start");

  // reset clears read data and core code
  reset_clr_a: assert property (@(posedge core_clk)
    reset |=> rdata == 8'h00 && core_code == 8'h00 && !st_r.ctrl.converter_enable)
    else $error("reset did not clear registers");

  // reset stops a running conversion at once
  reset_off_a: assert property (@(posedge core_clk)
    reset |=> !core_power_up && !analog_out_pin_oe)
    else $error("reset did not power down");

  // pin driven only with both enables set
  drive_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    analog_out_pin_oe |-> (st_r.ctrl.converter_enable && st_r.ctrl.output_drive_enable))
    else $error("pin driven while disabled");

  // stop-in-wait parks the core during wait mode
  wait_stop_a: assert property (@(posedge core_clk) disable iff (reset)
    (st_r.ctrl.stop_in_wait && wait_mode) |=> !core_power_up)
    else $error("wait mode did not stop");

  // control writes never touch the stored value
  keep_val_a: assert property (@(posedge core_clk) disable iff (reset)
    (wr && hit(addr, dac_fmt_pkg::CTRL_OFS)) |=> $stable(st_r.value))
    else $error("select change altered value");

  // main scenarios reached
  cv_signed_c: cover property (@(posedge core_clk) st_r.ctrl.signed_format_sel && converting);
  cv_right_c: cover property (@(posedge core_clk) wr && addr == dac_fmt_pkg::RIGHT_OFS && st_r.ctrl.justify_right_sel);
  cv_drive_c: cover property (@(posedge core_clk) analog_out_pin_oe);
  cv_left_c: cover property (@(posedge core_clk) wr && addr == dac_fmt_pkg::LEFT_OFS && !st_r.ctrl.justify_right_sel);
  cv_wait_c: cover property (@(posedge core_clk) st_r.ctrl.converter_enable && st_r.ctrl.stop_in_wait && wait_mode);
endmodule : dac_format_ctrl
`default_nettype wire

// *** verif/tb_dac_format_ctrl.sv ***
// testbench: register access, data formats, enables and reset of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_dac_format_ctrl;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wait_mode = 1'b0;
  logic rd_seen = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, core_code, v;
  logic core_power_up, converting, analog_out_pin_oe;
  logic [31:0] seed = 32'h6CE0E6E6;
  logic [7:0] rq[$];
  int miscompares = 0;
  int total_checks = 0;
  // block under test
  dac_format_ctrl dut_u (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wait_mode(wait_mode), .core_code(core_code), .core_power_up(core_power_up),
    .converting(converting), .analog_out_pin_oe(analog_out_pin_oe));
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // one bus cycle, all signals changed just after the edge
  task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : bus
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wreg
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rreg
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 2'h0, 8'h00);
  endtask : idle
  // outputs looked at mid-cycle, where they are settled
  task automatic outs(input logic [7:0] c, input logic p, input logic oe);
    @(negedge core_clk);
    chk(core_code, c);
    chk({7'h00, core_power_up}, {7'h00, p});
    chk({7'h00, converting}, {7'h00, p});
    chk({7'h00, analog_out_pin_oe}, {7'h00, oe});
    @(posedge core_clk);
  endtask : outs
  // read data stand one cycle after the strobe: compare against the oldest note
  always @(posedge core_clk) begin
    if (rd_seen) chk(rdata, rq.pop_front());
    rd_seen <= rd;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    idle(1);
    outs(8'h00, 1'b0, 1'b0);
    rreg(2'h0, 8'h00);
    wreg(2'h0, 8'h80);
    wreg(2'h2, 8'hA5);
    wreg(2'h3, 8'h11);
    rreg(2'h2, 8'hA5);
    rreg(2'h3, 8'h00);
    rreg(2'h1, 8'h00);
    idle(3);
    outs(8'hA5, 1'b1, 1'b0);
    wreg(2'h0, 8'h88);
    rreg(2'h3, 8'hA5);
    rreg(2'h2, 8'h00);
    seed = xs(seed);
    v = seed[7:0];
    wreg(2'h3, v);
    rreg(2'h3, v);
    idle(3);
    outs(v, 1'b1, 1'b0);
    wreg(2'h0, 8'h8C);
    idle(3);
    outs(v ^ 8'h80, 1'b1, 1'b0);
    rreg(2'h3, v);
    wreg(2'h3, 8'h7F);
    idle(3);
    outs(8'hFF, 1'b1, 1'b0);
    wreg(2'h3, 8'h80);
    wreg(2'h0, 8'h8D);
    idle(3);
    outs(8'h00, 1'b1, 1'b1);
    wreg(2'h0, 8'h0D);
    idle(3);
    chk({7'h00, analog_out_pin_oe}, 8'h00);
    wreg(2'h0, 8'h8F);
    wait_mode <= 1'b1;
    idle(3);
    chk({7'h00, core_power_up}, 8'h00);
    wait_mode <= 1'b0;
    idle(3);
    outs(8'h00, 1'b1, 1'b1);
    reset <= 1'b1;
    idle(2);
    outs(8'h00, 1'b0, 1'b0);
    reset <= 1'b0;
    idle(1);
    rreg(2'h0, 8'h00);
    rreg(2'h2, 8'h00);
    idle(2);
    results();
  end
endmodule : tb_dac_format_ctrl
`default_nettype wire
